// *** verilog/rbm_pkg.sv ***
// Shared constants and types for the receive backplane multiplexed port.
package rbm_pkg;
  // Register port widths.
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  // Register offsets.
  localparam logic [ADDR_W-1:0] CTRL_OFFSET = 8'h22;
  localparam logic [ADDR_W-1:0] STATUS_OFFSET = 8'h24;
  // Control register field positions and reset values.
  localparam int RATE_LSB = 0;
  localparam int RATE_MSB = 1;
  localparam int MUX_EN_BIT = 7;
  localparam logic [1:0] RATE_RESET = 2'h0;
  localparam logic MUX_EN_RESET = 1'b0;
  // Status register field positions.
  localparam int ALIGNED_BIT = 0;
  localparam int SYNC_ERR_BIT = 1;
  // Rate codes that select a multiplexed mode.
  localparam logic [1:0] RATE_MVIP = 2'h2;
  localparam logic [1:0] RATE_H100 = 2'h3;
  // Frame geometry at 16.384 Mbit/s and 8 kHz frames.
  localparam int SERIAL_RATE_HZ = 16384000;
  localparam int FRAME_RATE_HZ = 8000;
  localparam int FRAME_BITS = SERIAL_RATE_HZ / FRAME_RATE_HZ;
  localparam int BIT_IDX_W = $clog2(FRAME_BITS);
  localparam int CHANNELS = 4;
  // Frame sync lengths in bit periods for each mode.
  localparam logic [2:0] SYNC_LEN_MVIP = 3'h4;
  localparam logic [2:0] SYNC_LEN_H100 = 3'h2;
  // Port operating state, one-hot.
  typedef enum logic [2:0] {
    RBM_OFF = 3'b001,
    RBM_HUNT = 3'b010,
    RBM_RUN = 3'b100
  } rbm_mode_type;
  // Register access bundle from software.
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } rbm_bus_type;
  // Byte fetch request towards the line channel buffers.
  typedef struct packed {
    logic req;
    logic [1:0] chan;
    logic [5:0] slot;
  } rbm_fetch_type;
endpackage : rbm_pkg

// *** verilog/rbm_edge_sync.sv ***
// Synchroniser and rising-edge finder for the backplane clock and frame sync.
`timescale 1ns/1ns
module rbm_edge_sync (
  // Clock and reset.
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  // Backplane pins.
  input wire logic rx_serial_clock_in,
  input wire logic rx_frame_sync_in,
  // Synchronised results.
  output logic clk_rise_out,
  output logic sync_level_out
);
  // All state of this module.
  typedef struct packed {
    logic [1:0] meta;
    logic [1:0] stable;
    logic clk_prev;
  } rbm_sync_state_type;

  rbm_sync_state_type st;
  rbm_sync_state_type next_st;
  logic [1:0] pins;

  // Pin bundle, clock in bit 0 and frame sync in bit 1.
  assign pins = {rx_frame_sync_in, rx_serial_clock_in};

  // First stage feeds only the second; edges are found past the second.
  always_comb begin
    next_st = st;
    next_st.meta = pins;
    next_st.stable = st.meta;
    next_st.clk_prev = st.stable[0];
  end

  // State register.
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // A rising clock edge seen in the same cycle it leaves the synchroniser.
  assign clk_rise_out = st.stable[0] & ~st.clk_prev;
  assign sync_level_out = st.stable[1];
endmodule : rbm_edge_sync

// *** verilog/rbm_serializer.sv ***
// Byte holder and bit launcher for the multiplexed serial output.
`timescale 1ns/1ns
module rbm_serializer (
  // Clock and reset.
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  // Control from the port logic.
  input wire logic enable_in,
  input wire logic launch_in,
  input wire logic [2:0] bit_sel_in,
  input wire logic load_in,
  input wire logic [7:0] load_data_in,
  // Serial data.
  output logic serial_out
);
  // All state of this module.
  typedef struct packed {
    logic [7:0] hold;
    logic serial;
  } rbm_ser_state_type;

  rbm_ser_state_type st;
  rbm_ser_state_type next_st;

  // Bits leave most significant first; a disabled port holds the line low.
  always_comb begin
    next_st = st;
    if (load_in) begin
      next_st.hold = load_data_in;
    end
    if (!enable_in) begin
      next_st.serial = 1'b0;
    end else if (launch_in) begin
      next_st.serial = st.hold[3'h7 - bit_sel_in];
    end
  end

  // State register.
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign serial_out = st.serial;
endmodule : rbm_serializer

// *** verilog/rbm_port.sv ***
// Receive backplane port merging four line channels into one 16.384 Mbit/s stream.
//
// Operation
// - Two-bit rate field, bits 1-0, resets zero.
// - Code 10 interleaves four channels onto output.
// - H.100 uses same interleave, two-bit sync.
// - Each output bit launches on rising clock.
`timescale 1ns/1ns
module rbm_port (
  // Clock and reset.
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  // Software register port.
  input wire rbm_pkg::rbm_bus_type reg_bus_in,
  output logic [rbm_pkg::DATA_W-1:0] reg_rdata_out,
  // Backplane pins.
  input wire logic rx_serial_clock_in,
  input wire logic rx_frame_sync_in,
  output logic rx_serial_out,
  // Byte fetch from the line channel buffers.
  output rbm_pkg::rbm_fetch_type fetch_out,
  input wire logic [7:0] fetch_data_in
);
  // All state of the port.
  typedef struct packed {
    // Operating state: off, hunting for the frame sync, or aligned.
    rbm_pkg::rbm_mode_type mode;
    // Rate field of the control register.
    logic [1:0] rate;
    // Multiplexed mode enable of the control register.
    logic mux_en;
    // Sticky flag for a frame sync of the wrong length.
    logic sync_err;
    // Count of consecutive clock edges that sampled the sync high.
    logic [2:0] run_len;
    // Frame bit carried by the latest backplane clock edge.
    logic [rbm_pkg::BIT_IDX_W-1:0] bit_idx;
    // Read data, standing for one cycle after a read strobe.
    logic [rbm_pkg::DATA_W-1:0] rdata;
    // Byte fetch request towards the line channel buffers.
    rbm_pkg::rbm_fetch_type fetch;
    // One-cycle order to the shifter to put out a bit.
    logic launch;
    // Position within the byte of the bit to put out.
    logic [2:0] launch_bit;
  } rbm_port_state_type;

  rbm_port_state_type st;
  rbm_port_state_type next_st;

  // Synchronised backplane view.
  logic clk_rise;
  logic sync_level;
  // Mode decode.
  logic active;
  logic [2:0] sync_len;
  // Bit index after this edge and the byte slot that follows it.
  logic [rbm_pkg::BIT_IDX_W-1:0] idx_now;
  logic [7:0] next_slot;
  logic sync_end;
  logic sync_good;
  // Register port decode.
  logic wr_ctrl;
  logic wr_status;

  // Both backplane inputs pass two flip-flops before use.
  rbm_edge_sync u_sync (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .rx_serial_clock_in(rx_serial_clock_in),
    .rx_frame_sync_in(rx_frame_sync_in),
    .clk_rise_out(clk_rise),
    .sync_level_out(sync_level)
  );

  // Output shifter, loaded by the fetch answer.
  rbm_serializer u_ser (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .enable_in(st.mode == rbm_pkg::RBM_RUN),
    .launch_in(st.launch),
    .bit_sel_in(st.launch_bit),
    .load_in(st.fetch.req),
    .load_data_in(fetch_data_in),
    .serial_out(rx_serial_out)
  );

  // Only codes 10 and 11 with multiplexing enabled run the port.
  assign active = st.mux_en & st.rate[1];
  // Sync pulse length expected for the selected mode.
  assign sync_len = (st.rate == rbm_pkg::RATE_H100) ? rbm_pkg::SYNC_LEN_H100 :
                    rbm_pkg::SYNC_LEN_MVIP;

  // A sync run ends at the first edge that samples it low again.
  // The run length is judged before this edge's own sample is counted.
  assign sync_end = clk_rise & ~sync_level & (st.run_len != 3'h0);
  assign sync_good = (st.run_len == sync_len);

  // After a good run the edge launches bit half the run length into the frame.
  always_comb begin
    if (sync_end && sync_good) begin
      // The sync straddles the frame boundary, so half of it lies in this frame.
      idx_now = rbm_pkg::BIT_IDX_W'(sync_len >> 1);
    end else begin
      // Otherwise count on; the index wraps at the frame length of 2048 bits.
      idx_now = st.bit_idx + rbm_pkg::BIT_IDX_W'(1);
    end
  end

  // Byte slot k carries channel k mod 4, timeslot k div 4.
  // The slot wraps from the last of a frame to the first.
  assign next_slot = idx_now[rbm_pkg::BIT_IDX_W-1:3] + 8'h01;

  // Register strobes.
  // The status register is read-only apart from the write-one clear.
  assign wr_ctrl = reg_bus_in.wr & (reg_bus_in.addr == rbm_pkg::CTRL_OFFSET);
  assign wr_status = reg_bus_in.wr & (reg_bus_in.addr == rbm_pkg::STATUS_OFFSET);

  // Next-state logic for registers, frame tracking and fetch.
  always_comb begin
    next_st = st;
    next_st.launch = 1'b0;
    next_st.fetch.req = 1'b0;
    // Control register write.
    if (wr_ctrl) begin
      next_st.rate = reg_bus_in.wdata[rbm_pkg::RATE_MSB:rbm_pkg::RATE_LSB];
      // Bits other than the rate field and the enable are not stored.
      next_st.mux_en = reg_bus_in.wdata[rbm_pkg::MUX_EN_BIT];
    end
    // Writing one clears the sync error flag.
    if (wr_status && reg_bus_in.wdata[rbm_pkg::SYNC_ERR_BIT]) begin
      next_st.sync_err = 1'b0;
    end
    // Read data stand in the cycle after the read strobe only.
    next_st.rdata = '0;
    if (reg_bus_in.rd) begin
      case (reg_bus_in.addr)
        rbm_pkg::CTRL_OFFSET: begin
          // Rate field and enable bit; other bits read zero.
          next_st.rdata[rbm_pkg::RATE_MSB:rbm_pkg::RATE_LSB] = st.rate;
          next_st.rdata[rbm_pkg::MUX_EN_BIT] = st.mux_en;
        end
        rbm_pkg::STATUS_OFFSET: begin
          // Alignment and sync error flags.
          next_st.rdata[rbm_pkg::ALIGNED_BIT] = (st.mode == rbm_pkg::RBM_RUN);
          next_st.rdata[rbm_pkg::SYNC_ERR_BIT] = st.sync_err;
        end
        default: begin
          // Unmapped addresses read zero.
          next_st.rdata = '0;
        end
      endcase
    end
    // Frame tracking on each rising backplane clock edge.
    if (!active) begin
      // Disabled or reserved setting: forget any partial sync run.
      next_st.mode = rbm_pkg::RBM_OFF;
      next_st.run_len = 3'h0;
    end else begin
      case (st.mode)
        rbm_pkg::RBM_OFF: begin
          // Start hunting for the frame sync.
          next_st.mode = rbm_pkg::RBM_HUNT;
        end
        rbm_pkg::RBM_HUNT, rbm_pkg::RBM_RUN: begin
          // Everything below moves only on a backplane clock edge.
          if (clk_rise) begin
            next_st.bit_idx = idx_now;
            // Count sync-high edges, saturating.
            if (sync_level) begin
              if (st.run_len != 3'h7) begin
                next_st.run_len = st.run_len + 3'h1;
              end
            end else begin
              // A low sample ends the run.
              next_st.run_len = 3'h0;
            end
            // A run of the wrong length drops alignment.
            if (sync_end && !sync_good) begin
              next_st.mode = rbm_pkg::RBM_HUNT;
            end else if (sync_end) begin
              next_st.mode = rbm_pkg::RBM_RUN;
            end
            // Launch the bit for this edge while aligned.
            if (next_st.mode == rbm_pkg::RBM_RUN) begin
              // The shifter reads its held byte at this same edge, so the fetch cannot disturb it.
              next_st.launch = 1'b1;
              next_st.launch_bit = idx_now[2:0];
              // After the last bit of a byte fetch the next slot's byte.
              if (idx_now[2:0] == 3'h7) begin
                next_st.fetch.req = 1'b1;
                next_st.fetch.chan = next_slot[1:0];
                next_st.fetch.slot = next_slot[7:2];
              end
            end
          end
        end
        default: begin
          // An illegal state code falls back to off.
          next_st.mode = rbm_pkg::RBM_OFF;
        end
      endcase
    end
    // A bad sync sets the error flag and wins over a clear.
    if (active && st.mode != rbm_pkg::RBM_OFF && sync_end && !sync_good) begin
      next_st.sync_err = 1'b1;
    end
  end

  // State register.
  // Reset puts the port off and the control fields at their reset values.
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st <= '0;
      st.mode <= rbm_pkg::RBM_OFF;
      st.rate <= rbm_pkg::RATE_RESET;
      st.mux_en <= rbm_pkg::MUX_EN_RESET;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from flip-flops.
  // The byte for a fetch must answer in the same cycle as the request.
  assign reg_rdata_out = st.rdata;
  assign fetch_out = st.fetch;

  // Checks run on the system clock and stop during reset.
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!rst_n_in);

  // A control write is seen in the rate field one cycle on.
  rate_write_a: assert property (
    wr_ctrl |=> st.rate == $past(reg_bus_in.wdata[rbm_pkg::RATE_MSB:rbm_pkg::RATE_LSB]))
    else $error("rate field did not take the written value");

  // A control read returns the rate field in the next cycle only.
  rate_read_a: assert property (
    (reg_bus_in.rd && reg_bus_in.addr == rbm_pkg::CTRL_OFFSET && !wr_ctrl)
    |=> reg_rdata_out[rbm_pkg::RATE_MSB:rbm_pkg::RATE_LSB] == st.rate)
    else $error("control read returned a wrong rate");

  // Read data fall back to zero when no read was made.
  rdata_idle_a: assert property (
    !reg_bus_in.rd |=> reg_rdata_out == '0)
    else $error("read data stood longer than one cycle");

  // A disabled or reserved setting keeps the serial line low.
  off_quiet_a: assert property (
    (st.mode == rbm_pkg::RBM_OFF)[*2] |-> rx_serial_out == 1'b0)
    else $error("serial output active while port is off");

  // The fetch leaves together with the launch of a byte's last bit.
  fetch_timing_a: assert property (
    fetch_out.req |-> st.launch && st.launch_bit == 3'h7)
    else $error("fetch not tied to a byte end");

  // A fetch asks for the byte slot after the one whose last bit just left.
  slot_order_a: assert property (
    fetch_out.req |->
      {fetch_out.slot, fetch_out.chan} == st.bit_idx[rbm_pkg::BIT_IDX_W-1:3] + 8'h01)
    else $error("fetch asked for the wrong byte slot");

  // A port that is off asks for no bytes.
  off_no_fetch_a: assert property (
    (st.mode == rbm_pkg::RBM_OFF) |=> !fetch_out.req)
    else $error("fetch issued while port is off");

  // A sync run of the wrong length raises the error flag.
  sync_err_set_a: assert property (
    (active && st.mode != rbm_pkg::RBM_OFF && sync_end && !sync_good) |=> st.sync_err)
    else $error("wrong sync length not flagged");

  // H.100 alignment resumes the frame at bit one, MVIP at bit two.
  align_point_a: assert property (
    (active && st.mode != rbm_pkg::RBM_OFF && sync_end && sync_good)
    |=> st.bit_idx == ((st.rate == rbm_pkg::RATE_H100) ? 11'h001 : 11'h002))
    else $error("frame alignment landed on the wrong bit");

  // The serial output moves only one cycle after a launch.
  launch_edge_a: assert property (
    $changed(rx_serial_out) && $past(st.mode) == rbm_pkg::RBM_RUN |-> $past(st.launch))
    else $error("serial output changed without a clock edge");

  // A bit goes out only on an edge found past the synchroniser.
  launch_rise_a: assert property (
    st.launch |-> $past(clk_rise))
    else $error("bit launched without a backplane clock edge");

  // No bit is launched while hunting for the frame sync.
  hunt_silent_a: assert property (
    (st.mode == rbm_pkg::RBM_HUNT) |-> !st.launch)
    else $error("bit launched before alignment");

  // Scenarios worth seeing.
  mvip_run_c: cover property (st.mode == rbm_pkg::RBM_RUN && st.rate == rbm_pkg::RATE_MVIP);
  h100_run_c: cover property (st.mode == rbm_pkg::RBM_RUN && st.rate == rbm_pkg::RATE_H100);
  sync_err_c: cover property ($rose(st.sync_err));
  fetch_c: cover property (fetch_out.req && fetch_out.chan == 2'h3);
  err_clear_c: cover property (wr_status && reg_bus_in.wdata[rbm_pkg::SYNC_ERR_BIT] && st.sync_err);
endmodule : rbm_port

// *** testbench/rbm_bp_ctrl.sv ***
// Behavioural backplane controller that supplies the serial clock and frame sync.
`timescale 1ns/1ns
module rbm_bp_ctrl (
  // Control from the bench.
  input wire logic run_in,
  input wire logic [1:0] half_len_in,
  // Backplane pins and the index of the latest clock rise.
  output logic serial_clk_out,
  output logic frame_sync_out,
  output logic [10:0] bit_idx_out
);
  // The clock stands still low between runs; a run starts a few bits before a frame end.
  initial begin
    serial_clk_out = 1'b0;
    frame_sync_out = 1'b0;
    bit_idx_out = 11'h7f7;
    forever begin
      if (run_in !== 1'b1) begin
        serial_clk_out = 1'b0;
        frame_sync_out = 1'b0;
        bit_idx_out = 11'h7f7;
        #12;
      end else begin
        // Rising edge carries the next frame bit.
        serial_clk_out = 1'b1;
        bit_idx_out = bit_idx_out + 11'h1;
        #200;
        // Sync changes at mid-bit, high for half_len bits either side of the boundary.
        serial_clk_out = 1'b0;
        frame_sync_out = (bit_idx_out + 11'h1 + {9'h0, half_len_in}) <
                         {8'h0, half_len_in, 1'b0};
        #200;
      end
    end
  end
endmodule : rbm_bp_ctrl

// *** testbench/rbm_port_tb.sv ***
// Self-checking bench for the receive backplane multiplexed port.
`timescale 1ns/1ns
module rbm_port_tb;
  // Design connections.
  logic clk_sys_in;
  logic rst_n_in;
  rbm_pkg::rbm_bus_type bus;
  logic [7:0] rdata;
  logic sclk;
  logic fsync;
  logic sout;
  rbm_pkg::rbm_fetch_type fetch;
  logic [7:0] fdata;
  // Partner control and model state.
  logic run;
  logic [1:0] half;
  logic [10:0] bidx;
  logic [7:0] mem [256];
  logic [7:0] k;
  logic [7:0] v;
  logic [31:0] seed;
  logic le;
  logic q [$];
  bit lv;
  bit chk_on;
  int mismatches;
  int total_checks;
  int nfetch;
  int i;

  rbm_port i_rbm_port (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .reg_bus_in(bus),
    .reg_rdata_out(rdata), .rx_serial_clock_in(sclk), .rx_frame_sync_in(fsync),
    .rx_serial_out(sout), .fetch_out(fetch), .fetch_data_in(fdata));
  rbm_bp_ctrl i_rbm_bp_ctrl (.run_in(run), .half_len_in(half), .serial_clk_out(sclk),
    .frame_sync_out(fsync), .bit_idx_out(bidx));

  // Line channel buffers answer a fetch at once from a random table.
  assign fdata = mem[{fetch.slot, fetch.chan}];

  // System clock, 50 ns period.
  initial begin
    clk_sys_in = 1'b0;
    forever #25 clk_sys_in = ~clk_sys_in;
  end

  // Seeded xorshift step.
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction : xs

  // Compares and reports one value.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk

  // Prints the verdict and ends the run.
  task automatic test_done();
    if (mismatches == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : test_done

  // One-cycle register write.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    bus.addr <= a;
    bus.wdata <= d;
    bus.wr <= 1'b1;
    @(posedge clk_sys_in);
    bus.wr <= 1'b0;
  endtask : wr

  // One-cycle register read; data stands in the following cycle only.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys_in);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge clk_sys_in);
    bus.rd <= 1'b0;
    #1 d = rdata;
  endtask : rd

  // Each fetch must ask for the byte slot after the one in flight; queue its bits.
  always @(posedge clk_sys_in) begin
    if (chk_on && fetch.req === 1'b1) begin
      nfetch++;
      k = bidx[10:3] + 8'h1;
      chk({fetch.slot, fetch.chan}, k);
      for (int b = 7; b >= 0; b--) q.push_back(mem[k][b]);
    end
  end

  // A bit launched at one link rise is judged at the next rise.
  always @(posedge sclk) begin
    if (chk_on) begin
      if (lv) chk(sout, le);
      lv = q.size() > 0;
      if (lv) le = q.pop_front();
    end
  end

  // Main sequence.
  initial begin
    seed = 32'h144b;
    for (i = 0; i < 256; i++) begin
      seed = xs(seed);
      mem[i] = seed[7:0];
    end
    bus = '0;
    rst_n_in = 1'b0;
    run = 1'b0;
    half = 2'h2;
    chk_on = 0;
    repeat (8) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    rd(rbm_pkg::CTRL_OFFSET, v);
    chk(v, 8'h00);
    rd(8'h23, v);
    chk(v, 8'h00);
    wr(rbm_pkg::CTRL_OFFSET, 8'hff);
    rd(rbm_pkg::CTRL_OFFSET, v);
    chk(v, 8'h83);
    // Reserved codes keep the port silent.
    for (i = 0; i < 2; i++) begin
      wr(rbm_pkg::CTRL_OFFSET, 8'h80 | 8'(i));
      nfetch = 0;
      chk_on = 1;
      run <= 1'b1;
      repeat (600) @(posedge clk_sys_in);
      chk(nfetch, 0);
      chk(sout, 1'b0);
      run <= 1'b0;
      chk_on = 0;
      repeat (20) @(posedge clk_sys_in);
    end
    // Both multiplexed modes with their own sync length.
    for (i = 0; i < 2; i++) begin
      wr(rbm_pkg::CTRL_OFFSET, 8'h00);
      wr(rbm_pkg::CTRL_OFFSET, (i == 1) ? 8'h83 : 8'h82);
      half <= (i == 1) ? 2'h1 : 2'h2;
      q.delete();
      lv = 0;
      nfetch = 0;
      chk_on = 1;
      run <= 1'b1;
      for (int t = 0; t < 40000 && nfetch < 300; t++) @(posedge clk_sys_in);
      if (nfetch < 300) begin
        mismatches++;
        test_done();
      end
      rd(rbm_pkg::STATUS_OFFSET, v);
      chk(v, 8'h01);
      run <= 1'b0;
      chk_on = 0;
      repeat (20) @(posedge clk_sys_in);
    end
    // A four-bit sync in the two-bit mode is a framing error.
    wr(rbm_pkg::CTRL_OFFSET, 8'h00);
    wr(rbm_pkg::CTRL_OFFSET, 8'h83);
    half <= 2'h2;
    run <= 1'b1;
    v = 8'h00;
    for (int t = 0; t < 200 && v[1] !== 1'b1; t++) rd(rbm_pkg::STATUS_OFFSET, v);
    if (v[1] !== 1'b1) begin
      mismatches++;
      test_done();
    end
    chk(v, 8'h02);
    run <= 1'b0;
    repeat (20) @(posedge clk_sys_in);
    wr(rbm_pkg::STATUS_OFFSET, 8'h02);
    rd(rbm_pkg::STATUS_OFFSET, v);
    chk(v, 8'h00);
    test_done();
  end
endmodule : rbm_port_tb
